//--- rtl/dual_adc_pkg.sv
// Shared constants and types for the dual converter sequencer
package dual_adc_pkg;
    localparam int NCONV = 2;
    localparam int NPIN = 16;
    localparam int CH_W = 4;
    localparam int RES_W = 10;
    localparam int SHORT_W = 8;
    localparam int SHORT_SHIFT = RES_W - SHORT_W;
    localparam int ACC_W = 13;
    localparam int ACCN_W = 3;
    localparam int NREG = 8;
    localparam int REG_W = 3;
    localparam int QDEPTH = 4;
    localparam int QIX_W = 2;
    localparam int QCNT_W = 3;
    localparam logic [QCNT_W-1:0] Q_FULL = 3'h4;
    localparam int EMUX_W = 3;
    localparam int PRIO_W = 2;
    localparam int TRIG_N = 8;
    localparam int TRIG_W = 3;
    localparam int SMP_W = 8;
    localparam int BIT_W = 4;
    localparam int SHARED_N = 4;
    // Channels 0..10 on the first converter; 4 shared plus 5 own on the second
    localparam logic [NCONV-1:0][NPIN-1:0] CH_MASK = {16'h01ff, 16'h07ff};
    localparam logic [CH_W-1:0] PIN_BASE1 = 4'h7;
    localparam logic [BIT_W-1:0] MSB_IX = 4'h9;
    localparam logic [BIT_W-1:0] LSB_SHORT = 4'h2;
    localparam logic [SMP_W-1:0] WAKE_CYC = 8'h04;
    localparam logic [3:0] PRECHG_CYC = 4'h2;
    typedef enum logic [1:0] {SRC_PAR, SRC_Q, SRC_INS} src_e;
    typedef enum logic [1:0] {C_IDLE, C_WAKE, C_SAMPLE, C_CONV} core_state_e;
endpackage

//--- rtl/adc_sar_core.sv
// Successive approximation converter core with auto power-down
module adc_sar_core
    import dual_adc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [SMP_W-1:0] sampleLen,
    input wire logic [BIT_W-1:0] bitLen,
    input wire logic shortMode,
    input wire logic cmpHigh,
    output logic busy,
    output logic sampling,
    output logic powerOn,
    output logic [RES_W-1:0] dacCode,
    output logic done,
    output logic [RES_W-1:0] result
);
    typedef struct packed {
        core_state_e st;
        logic [SMP_W-1:0] cnt;
        logic [BIT_W-1:0] bitIx;
        logic [RES_W-1:0] code;
        logic [RES_W-1:0] res;
        logic done;
        logic short;
    } core_s;

    core_s cur;
    core_s next_cur;
    logic [RES_W-1:0] trial;
    logic [RES_W-1:0] fin;

    always_comb begin
        next_cur = cur;
        next_cur.done = 1'b0;
        trial = cur.code | (RES_W'(1) << cur.bitIx);
        fin = cmpHigh ? trial : cur.code;
        case (cur.st)
            C_IDLE: begin
                if (start) begin
                    // Analog part is off while idle, so every start wakes it
                    next_cur.st = C_WAKE;
                    next_cur.cnt = WAKE_CYC;
                    next_cur.short = shortMode;
                end
            end
            C_WAKE: begin
                next_cur.cnt = cur.cnt - 8'h01;
                if (cur.cnt <= 8'h01) begin
                    next_cur.st = C_SAMPLE;
                    next_cur.cnt = sampleLen;
                end
            end
            C_SAMPLE: begin
                next_cur.cnt = cur.cnt - 8'h01;
                if (cur.cnt <= 8'h01) begin
                    next_cur.st = C_CONV;
                    next_cur.cnt = SMP_W'(bitLen);
                    next_cur.bitIx = MSB_IX;
                    next_cur.code = '0;
                end
            end
            C_CONV: begin
                next_cur.cnt = cur.cnt - 8'h01;
                if (cur.cnt <= 8'h01) begin
                    next_cur.cnt = SMP_W'(bitLen);
                    next_cur.code = fin;
                    next_cur.bitIx = cur.bitIx - 4'h1;
                    if (cur.bitIx == (cur.short ? LSB_SHORT : 4'h0)) begin
                        next_cur.st = C_IDLE;
                        next_cur.done = 1'b1;
                        next_cur.res = cur.short ? (fin >> SHORT_SHIFT) : fin;
                    end
                end
            end
            default: next_cur.st = C_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign busy = (cur.st != C_IDLE);
    assign powerOn = (cur.st != C_IDLE);
    assign sampling = (cur.st == C_SAMPLE);
    assign dacCode = (cur.st == C_CONV) ? trial : '0;
    assign done = cur.done;
    assign result = cur.res;

    property p_short_res;
        @(posedge sys_clk) disable iff (rst)
        (done && cur.short) |-> (result[RES_W-1:SHORT_W] == '0);
    endproperty
    a_short_res: assert property (p_short_res)
        else $error("short mode result exceeds 8 bits");
endmodule // adc_sar_core

//--- rtl/dual_adc_sequencer.sv
// Request sequencing, arbitration and result handling for two converters
// Functional notes
// - Two independent converters, 10-bit successive approximation results.
// - 11 plus 5 inputs multiplexed; four inputs reachable by both.
// - Sample and conversion durations set by software.
// - Reduced 8-bit mode with shorter conversion time.
// - Synchronized mode samples two channels at the same moment.
// - External multiplexer select outputs driven automatically.
// - Unused channel pins still work as digital inputs.
// - Internal and external trigger events start requests.
// - Parallel source sets all selected channels, converts in fixed order.
// - Queue source converts entries in software order.
// - Inserted single conversion leaves running sequence intact.
// - Highest priority pending request converts next.
// - Eight result registers per converter, chainable as FIFO.
// - Per-register wait-for-read option prevents losing unread results.
// - Limit checking and accumulation reduce result data.
// - Several result registers and selectable conversion event requests.
// - Analog part powers down whenever no conversion runs.
// - Per-channel open-input detection and multiplexer test mode.
module dual_adc_sequencer
    import dual_adc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [TRIG_N-1:0] trigIn,
    input wire logic [NCONV-1:0][NPIN-1:0] parMask,
    input wire logic [NCONV-1:0][TRIG_W-1:0] parTrigSel,
    input wire logic [NCONV-1:0] parSwStart,
    input wire logic [NCONV-1:0] qPush,
    input wire logic [NCONV-1:0][CH_W-1:0] qPushCh,
    output logic [NCONV-1:0] qFull,
    input wire logic [NCONV-1:0] insReq,
    input wire logic [NCONV-1:0][CH_W-1:0] insCh,
    input wire logic [NCONV-1:0][PRIO_W-1:0] prioPar,
    input wire logic [NCONV-1:0][PRIO_W-1:0] prioQ,
    input wire logic [NCONV-1:0][PRIO_W-1:0] prioIns,
    input wire logic [NCONV-1:0][SMP_W-1:0] sampleLen,
    input wire logic [NCONV-1:0][BIT_W-1:0] bitLen,
    input wire logic [NCONV-1:0] shortMode,
    input wire logic syncMode,
    input wire logic [CH_W-1:0] syncCh,
    input wire logic [NCONV-1:0] emuxEn,
    input wire logic [NCONV-1:0][CH_W-1:0] emuxCh,
    output logic [NCONV-1:0][EMUX_W-1:0] emuxSel,
    input wire logic [NCONV-1:0] cmpHigh,
    output logic [NCONV-1:0][RES_W-1:0] dacCode,
    output logic [NCONV-1:0][CH_W-1:0] anaPin,
    output logic [NCONV-1:0] anaPowerOn,
    output logic [NCONV-1:0] sampling,
    input wire logic [NPIN-1:0] portIn,
    input wire logic [NPIN-1:0] digDisable,
    output logic [NPIN-1:0] digitalIn,
    input wire logic [NCONV-1:0] fifoEn,
    input wire logic [NCONV-1:0][NREG-1:0] wfr,
    input wire logic [NCONV-1:0][ACCN_W-1:0] accN,
    input wire logic [NCONV-1:0][RES_W-1:0] limLo,
    input wire logic [NCONV-1:0][RES_W-1:0] limHi,
    output logic [NCONV-1:0] limEvent,
    input wire logic [NCONV-1:0][NREG-1:0] resEvEn,
    output logic [NCONV-1:0] resEvent,
    input wire logic rdReq,
    input wire logic rdConv,
    input wire logic [REG_W-1:0] rdIdx,
    output logic [ACC_W-1:0] rdData,
    output logic rdValid,
    output logic [NCONV-1:0][NREG-1:0] regValid,
    input wire logic [NCONV-1:0][NPIN-1:0] bwEn,
    output logic [NCONV-1:0] preCharge,
    input wire logic [NCONV-1:0] muxTest,
    output logic [NCONV-1:0] muxTestOn,
    output logic [NCONV-1:0] busy
);
    typedef struct packed {
        logic [NCONV-1:0][NPIN-1:0] parPend;
        logic [NCONV-1:0][QDEPTH-1:0][CH_W-1:0] qCh;
        logic [NCONV-1:0][QCNT_W-1:0] qCnt;
        logic [NCONV-1:0] insPend;
        logic [NCONV-1:0][CH_W-1:0] insCh;
        logic [NCONV-1:0] active;
        logic [NCONV-1:0][CH_W-1:0] curCh;
        logic [NCONV-1:0][REG_W-1:0] curReg;
        logic [NCONV-1:0][REG_W-1:0] wrPtr;
        logic [NCONV-1:0][ACCN_W-1:0] accCnt;
        logic [NCONV-1:0][NREG-1:0][ACC_W-1:0] res;
        logic [NCONV-1:0][NREG-1:0] vld;
        logic [NCONV-1:0][EMUX_W-1:0] emux;
        logic [NCONV-1:0] limEv;
        logic [NCONV-1:0] resEv;
        logic [ACC_W-1:0] rdData;
        logic rdValid;
        logic [NPIN-1:0] digIn;
        logic [NCONV-1:0][3:0] pcCnt;
    } seq_s;

    seq_s cur;
    seq_s next_cur;
    logic [NCONV-1:0] start;
    logic [NCONV-1:0] ready;
    logic [NCONV-1:0] hasSrc;
    logic [NCONV-1:0] blocked;
    logic [NCONV-1:0] trig;
    logic [NCONV-1:0][1:0] srcSel;
    logic [NCONV-1:0][PRIO_W-1:0] bestPrio;
    logic [NCONV-1:0][CH_W-1:0] parCh;
    logic [NCONV-1:0][CH_W-1:0] pickCh;
    logic [NCONV-1:0][REG_W-1:0] tgt;
    logic [NCONV-1:0] cDone;
    logic [NCONV-1:0] coreBusy;
    logic [NCONV-1:0][RES_W-1:0] cRes;

    // Arbitration among parallel, queued and inserted requests
    always_comb begin
        parCh = '0;
        hasSrc = '0;
        srcSel = '0;
        bestPrio = '0;
        pickCh = '0;
        tgt = '0;
        blocked = '0;
        ready = '0;
        trig = '0;
        for (int c = 0; c < NCONV; c++) begin
            trig[c] = parSwStart[c] | trigIn[parTrigSel[c]];
            // Fixed order: lowest pending channel first
            for (int i = NPIN - 1; i >= 0; i--) begin
                if (cur.parPend[c][i]) begin
                    parCh[c] = CH_W'(i);
                end
            end
            hasSrc[c] = |cur.parPend[c];
            srcSel[c] = SRC_PAR;
            pickCh[c] = parCh[c];
            bestPrio[c] = prioPar[c];
            // Equal priority: insert beats queue beats parallel
            if (cur.qCnt[c] != '0 && (!hasSrc[c] || prioQ[c] >= bestPrio[c])) begin
                hasSrc[c] = 1'b1;
                srcSel[c] = SRC_Q;
                pickCh[c] = cur.qCh[c][0];
                bestPrio[c] = prioQ[c];
            end
            if (cur.insPend[c] && (!hasSrc[c] || prioIns[c] >= bestPrio[c])) begin
                hasSrc[c] = 1'b1;
                srcSel[c] = SRC_INS;
                pickCh[c] = cur.insCh[c];
                bestPrio[c] = prioIns[c];
            end
            if (c == 1 && syncMode) begin
                pickCh[c] = syncCh;
            end
            tgt[c] = fifoEn[c] ? cur.wrPtr[c] : pickCh[c][REG_W-1:0];
            blocked[c] = wfr[c][tgt[c]] && cur.vld[c][tgt[c]];
            ready[c] = !cur.active[c] && !coreBusy[c] && !blocked[c];
        end
        // Slave converter starts in the same cycle as the master
        start[0] = ready[0] && hasSrc[0] && (!syncMode || ready[1]);
        start[1] = syncMode ? start[0] : (ready[1] && hasSrc[1]);
    end

    always_comb begin
        next_cur = cur;
        next_cur.limEv = '0;
        next_cur.resEv = '0;
        next_cur.digIn = portIn & ~digDisable;
        // Read first so that a same-cycle result write wins
        if (rdReq) begin
            next_cur.rdData = cur.res[rdConv][rdIdx];
            next_cur.rdValid = cur.vld[rdConv][rdIdx];
            next_cur.vld[rdConv][rdIdx] = 1'b0;
        end
        for (int c = 0; c < NCONV; c++) begin
            if (cur.pcCnt[c] != '0 && sampling[c]) begin
                next_cur.pcCnt[c] = cur.pcCnt[c] - 4'h1;
            end
            if (start[c]) begin
                next_cur.active[c] = 1'b1;
                next_cur.curCh[c] = pickCh[c];
                next_cur.curReg[c] = tgt[c];
                next_cur.pcCnt[c] = bwEn[c][pickCh[c]] ? PRECHG_CYC : 4'h0;
                if (!(c == 1 && syncMode)) begin
                    case (srcSel[c])
                        SRC_INS: next_cur.insPend[c] = 1'b0;
                        SRC_Q: begin
                            for (int q = 0; q < QDEPTH - 1; q++) begin
                                next_cur.qCh[c][q] = cur.qCh[c][q+1];
                            end
                            next_cur.qCnt[c] = cur.qCnt[c] - 3'h1;
                        end
                        default: next_cur.parPend[c][pickCh[c]] = 1'b0;
                    endcase
                end
            end
            if (qPush[c] && next_cur.qCnt[c] != Q_FULL && CH_MASK[c][qPushCh[c]]) begin
                next_cur.qCh[c][next_cur.qCnt[c][QIX_W-1:0]] = qPushCh[c];
                next_cur.qCnt[c] = next_cur.qCnt[c] + 3'h1;
            end
            if (insReq[c] && CH_MASK[c][insCh[c]]) begin
                next_cur.insPend[c] = 1'b1;
                next_cur.insCh[c] = insCh[c];
            end
            if (trig[c]) begin
                next_cur.parPend[c] = next_cur.parPend[c] | (parMask[c] & CH_MASK[c]);
            end
            if (cDone[c]) begin
                next_cur.active[c] = 1'b0;
                if (cur.accCnt[c] == '0) begin
                    next_cur.res[c][cur.curReg[c]] = ACC_W'(cRes[c]);
                end else begin
                    next_cur.res[c][cur.curReg[c]] =
                        cur.res[c][cur.curReg[c]] + ACC_W'(cRes[c]);
                end
                if (cur.accCnt[c] >= accN[c]) begin
                    next_cur.accCnt[c] = '0;
                    next_cur.vld[c][cur.curReg[c]] = 1'b1;
                    next_cur.resEv[c] = resEvEn[c][cur.curReg[c]];
                    if (fifoEn[c]) begin
                        next_cur.wrPtr[c] = cur.wrPtr[c] + 3'h1;
                    end
                end else begin
                    next_cur.accCnt[c] = cur.accCnt[c] + 3'h1;
                end
                next_cur.limEv[c] = (cRes[c] < limLo[c]) || (cRes[c] > limHi[c]);
                if (emuxEn[c] && cur.curCh[c] == emuxCh[c]) begin
                    next_cur.emux[c] = cur.emux[c] + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    for (genvar g = 0; g < NCONV; g++) begin : g_conv
        adc_sar_core u_core (
            .sys_clk(sys_clk),
            .rst(rst),
            .start(start[g]),
            .sampleLen(syncMode ? sampleLen[0] : sampleLen[g]),
            .bitLen(syncMode ? bitLen[0] : bitLen[g]),
            .shortMode(syncMode ? shortMode[0] : shortMode[g]),
            .cmpHigh(cmpHigh[g]),
            .busy(coreBusy[g]),
            .sampling(sampling[g]),
            .powerOn(anaPowerOn[g]),
            .dacCode(dacCode[g]),
            .done(cDone[g]),
            .result(cRes[g])
        );
        // Second converter: low channels are the shared pins
        if (g == 0) begin : g_map0
            assign anaPin[g] = cur.curCh[g];
        end else begin : g_map1
            assign anaPin[g] = (cur.curCh[g] < CH_W'(SHARED_N)) ?
                cur.curCh[g] : cur.curCh[g] + PIN_BASE1;
        end
        assign preCharge[g] = (cur.pcCnt[g] != '0);
        assign qFull[g] = (cur.qCnt[g] == Q_FULL);
    end

    assign muxTestOn = muxTest & cur.active;
    assign emuxSel = cur.emux;
    assign busy = cur.active;
    assign limEvent = cur.limEv;
    assign resEvent = cur.resEv;
    assign rdData = cur.rdData;
    assign rdValid = cur.rdValid;
    assign regValid = cur.vld;
    assign digitalIn = cur.digIn;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence s_awake;
        anaPowerOn[0] [*4];
    endsequence
    sequence s_idle_pd;
        !cur.active[0] ##1 !anaPowerOn[0];
    endsequence

    property p_power;
        start[0] |=> s_awake;
    endproperty
    a_power: assert property (p_power)
        else $error("analog part not powered after start");

    property p_pd;
        (!cur.active[0] && !start[0] && !coreBusy[0]) |-> s_idle_pd;
    endproperty
    a_pd: assert property (p_pd)
        else $error("analog part powered while idle");

    property p_wfr;
        start[0] |-> !(wfr[0][tgt[0]] && cur.vld[0][tgt[0]]);
    endproperty
    a_wfr: assert property (p_wfr)
        else $error("conversion started onto unread register");

    property p_sync;
        (syncMode && start[0]) |-> start[1];
    endproperty
    a_sync: assert property (p_sync)
        else $error("synchronized converters started apart");

    property p_par_order;
        (start[0] && srcSel[0] == SRC_PAR) |->
            ((cur.parPend[0] & ((16'h0001 << pickCh[0]) - 16'h0001)) == '0);
    endproperty
    a_par_order: assert property (p_par_order)
        else $error("parallel channel taken out of order");

    property p_q_order;
        (start[0] && srcSel[0] == SRC_Q && !syncMode) |=>
            (cur.curCh[0] == $past(cur.qCh[0][0]));
    endproperty
    a_q_order: assert property (p_q_order)
        else $error("queue head not converted first");

    property p_ins_keep;
        (start[0] && srcSel[0] == SRC_INS && !trig[0]) |=>
            (cur.parPend[0] == $past(cur.parPend[0]));
    endproperty
    a_ins_keep: assert property (p_ins_keep)
        else $error("insertion disturbed the parallel sequence");

    property p_prio;
        (start[0] && cur.insPend[0] && prioIns[0] >= prioQ[0]
            && prioIns[0] >= prioPar[0]) |-> (srcSel[0] == SRC_INS);
    endproperty
    a_prio: assert property (p_prio)
        else $error("lower priority request won arbitration");

    property p_valid;
        (cDone[0] && cur.accCnt[0] >= accN[0]) |=>
            (cur.vld[0][$past(cur.curReg[0])] && cur.resEv[0] == $past(resEvEn[0][cur.curReg[0]]));
    endproperty
    a_valid: assert property (p_valid)
        else $error("result written without valid flag");

    property p_rd_clear;
        (rdReq && !cDone[rdConv]) |=> !cur.vld[$past(rdConv)][$past(rdIdx)];
    endproperty
    a_rd_clear: assert property (p_rd_clear)
        else $error("read did not clear valid flag");
endmodule // dual_adc_sequencer

//--- tb/analog_source.sv
// Analog source model: per-pin levels behind a sample-and-hold comparator
module analog_source
    import dual_adc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [NPIN-1:0][RES_W-1:0] level,
    input wire logic [NCONV-1:0][CH_W-1:0] anaPin,
    input wire logic [NCONV-1:0] sampling,
    input wire logic [NCONV-1:0][RES_W-1:0] dacCode,
    output logic [NCONV-1:0] cmpHigh
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [NCONV-1:0][RES_W-1:0] held = '0;
    // Hold frozen outside the sample phase
    always @(posedge sys_clk) begin
        for (int c = 0; c < NCONV; c++)
            if (sampling[c]) held[c] <= level[anaPin[c]];
    end
    always_comb begin
        for (int c = 0; c < NCONV; c++)
            cmpHigh[c] = held[c] >= dacCode[c];
    end
endmodule // analog_source

//--- tb/tb_top.sv
// Self-checking bench for the dual converter sequencer
module tb_top
    import dual_adc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0, rst = 1'b1, syncMode = 1'b0, rdReq = 1'b0, rdConv = 1'b0;
    logic [TRIG_N-1:0] trigIn = '0;
    logic [NCONV-1:0][NPIN-1:0] parMask = '0, bwEn = '0;
    logic [NCONV-1:0][TRIG_W-1:0] parTrigSel = '0;
    logic [NCONV-1:0] parSwStart = '0, qPush = '0, insReq = '0, shortMode = '0;
    logic [NCONV-1:0] emuxEn = '0, fifoEn = '0, muxTest = '0;
    logic [NCONV-1:0][CH_W-1:0] qPushCh = '0, insCh = '0, emuxCh = '0;
    logic [NCONV-1:0][PRIO_W-1:0] prioPar = '0, prioQ = '0, prioIns = '0;
    logic [NCONV-1:0][SMP_W-1:0] sampleLen = {2{8'h03}};
    logic [NCONV-1:0][BIT_W-1:0] bitLen = {2{4'h1}};
    logic [CH_W-1:0] syncCh = 4'h5;
    logic [NPIN-1:0] portIn = '0, digDisable = '0;
    logic [NCONV-1:0][NREG-1:0] wfr = '0, resEvEn = '1;
    logic [NCONV-1:0][ACCN_W-1:0] accN = '0;
    logic [NCONV-1:0][RES_W-1:0] limLo = '0, limHi = '1;
    logic [REG_W-1:0] rdIdx = '0;
    logic [NPIN-1:0][RES_W-1:0] level = '0;
    logic [NCONV-1:0] qFull, cmpHigh, anaPowerOn, sampling, limEvent, resEvent;
    logic [NCONV-1:0] preCharge, muxTestOn, busy;
    logic [NCONV-1:0][EMUX_W-1:0] emuxSel;
    logic [NCONV-1:0][RES_W-1:0] dacCode;
    logic [NCONV-1:0][CH_W-1:0] anaPin;
    logic [NPIN-1:0] digitalIn;
    logic [ACC_W-1:0] rdData, d;
    logic rdValid, smpPrev = 1'b0;
    logic [NCONV-1:0][NREG-1:0] regValid;
    logic [CH_W-1:0] order[$];
    logic [31:0] seed = 32'hc69327fe;
    int n_errors = 0, checks = 0, cyc = 0, nLim = 0, nRes = 0, waitCyc, lastK, fullK;
    dual_adc_sequencer i_dual_adc_sequencer (.sys_clk, .rst, .trigIn, .parMask,
        .parTrigSel, .parSwStart, .qPush, .qPushCh, .qFull, .insReq, .insCh, .prioPar,
        .prioQ, .prioIns, .sampleLen, .bitLen, .shortMode, .syncMode, .syncCh, .emuxEn,
        .emuxCh, .emuxSel, .cmpHigh, .dacCode, .anaPin, .anaPowerOn, .sampling, .portIn,
        .digDisable, .digitalIn, .fifoEn, .wfr, .accN, .limLo, .limHi, .limEvent,
        .resEvEn, .resEvent, .rdReq, .rdConv, .rdIdx, .rdData, .rdValid, .regValid,
        .bwEn, .preCharge, .muxTest, .muxTestOn, .busy);
    analog_source i_analog_source (.sys_clk, .level, .anaPin, .sampling, .dacCode,
        .cmpHigh);
    always #50 sys_clk = ~sys_clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [ACC_W-1:0] exp_res(input logic [RES_W-1:0] v, input logic sm);
        return sm ? {5'h00, v[9:2]} : {3'h0, v};
    endfunction
    task automatic print_verdict();
        $display("Counts: checks=%0d mismatches=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic cmp_order(input logic [CH_W-1:0] e[$]);
        cmp(order.size(), e.size(), "sequence length");
        foreach (e[i]) if (i < order.size()) cmp(order[i], e[i], "sequence");
        order.delete();
    endtask
    task automatic ins(input int c, input logic [CH_W-1:0] ch);
        insCh[c] = ch;
        insReq[c] = 1'b1;
        @(negedge sys_clk);
        insReq[c] = 1'b0;
    endtask
    task automatic push(input logic [CH_W-1:0] q[$]);
        qPush[0] = 1'b1;
        foreach (q[i]) begin
            qPushCh[0] = q[i];
            @(negedge sys_clk);
        end
        qPush[0] = 1'b0;
    endtask
    task automatic wait_valid(input int c, input int idx);
        waitCyc = 0;
        while (regValid[c][idx] !== 1'b1 && waitCyc < 500) begin
            @(negedge sys_clk);
            waitCyc++;
        end
        cmp(waitCyc < 500, 1'b1, "result arrives");
    endtask
    task automatic read_reg(input int c, input int idx);
        @(negedge sys_clk);
        rdReq = 1'b1;
        rdConv = c[0];
        rdIdx = idx[2:0];
        @(negedge sys_clk);
        rdReq = 1'b0;
        d = rdData;
        cmp(regValid[c][idx], 1'b0, "valid cleared");
    endtask
    task automatic check_conv(input int c, input logic [CH_W-1:0] ch);
        logic [CH_W-1:0] p;
        p = (c == 1 && ch > 3) ? ch + PIN_BASE1 : ch;
        ins(c, ch);
        wait_valid(c, ch[2:0]);
        lastK = waitCyc;
        read_reg(c, ch[2:0]);
        cmp(d, exp_res(level[p], shortMode[c]), "result");
        cmp(rdValid, 1'b1, "read valid");
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (sampling[0] && !smpPrev) begin
            order.push_back(anaPin[0]);
            cmp(anaPowerOn[0], 1'b1, "powered while sampling");
            cmp(preCharge[0], bwEn[0][anaPin[0]], "precharge");
        end
        smpPrev = sampling[0];
        nLim += limEvent[0];
        nRes += resEvent[0];
        if (syncMode) cmp(sampling[1], sampling[0], "joint sampling");
        if (muxTest[0]) cmp(muxTestOn[0], busy[0], "mux test");
        if (cyc == 30000) begin
            n_errors++;
            print_verdict();
        end
    end
    initial begin
        for (int i = 0; i < NPIN; i++) begin
            seed = xs(seed);
            level[i] = seed[9:0];
        end
        bwEn[0] = seed[31:16];
        repeat (3) @(posedge sys_clk);
        cmp(regValid, '0, "reset valid");
        @(negedge sys_clk);
        rst = 1'b0;
        muxTest[0] = 1'b1;
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            check_conv(seed[4], seed[3:0] % (seed[4] ? 9 : 11));
        end
        check_conv(0, 4'ha);
        check_conv(1, 4'h8);
        ins(0, 4'hb);
        repeat (40) @(negedge sys_clk);
        cmp(regValid, '0, "range refusal");
        cmp(anaPowerOn, 2'b00, "idle power");
        $display("Test basic done");
        fullK = lastK;
        shortMode = 2'b11;
        check_conv(0, 4'h3);
        cmp(lastK < fullK, 1'b1, "short faster");
        shortMode = 2'b00;
        order.delete();
        push('{4'h6, 4'h2, 4'h9});
        wait_valid(0, 6);
        wait_valid(0, 2);
        wait_valid(0, 1);
        cmp_order('{4'h6, 4'h2, 4'h9});
        read_reg(0, 6);
        read_reg(0, 2);
        read_reg(0, 1);
        prioIns[0] = 2'h3;
        push('{4'h1, 4'h2});
        repeat (6) @(negedge sys_clk);
        ins(0, 4'h7);
        wait_valid(0, 1);
        wait_valid(0, 2);
        wait_valid(0, 7);
        cmp_order('{4'h1, 4'h7, 4'h2});
        $display("Test queue done");
        for (int k = 0; k < 2; k++) begin
            prioQ[0] = k ? 2'h1 : 2'h2;
            prioIns[0] = k ? 2'h3 : 2'h1;
            for (int r = 1; r < 8; r++) if (regValid[0][r]) read_reg(0, r);
            order.delete();
            qPushCh[0] = 4'h3;
            qPush[0] = 1'b1;
            ins(0, 4'h4);
            qPush[0] = 1'b0;
            wait_valid(0, 3);
            wait_valid(0, 4);
            cmp_order(k ? '{4'h4, 4'h3} : '{4'h3, 4'h4});
        end
        read_reg(0, 3);
        read_reg(0, 4);
        parMask[0] = 16'h0112;
        parSwStart[0] = 1'b1;
        @(negedge sys_clk);
        parSwStart[0] = 1'b0;
        wait_valid(0, 1);
        wait_valid(0, 4);
        wait_valid(0, 0);
        cmp(order.size(), 3, "parallel count");
        cmp((order[0] < order[1]) == (order[1] < order[2]), 1'b1, "fixed order");
        order.delete();
        parMask[0] = 16'h0020;
        parTrigSel[0] = 3'h3;
        trigIn[3] = 1'b1;
        @(negedge sys_clk);
        trigIn[3] = 1'b0;
        parMask[0] = '0;
        wait_valid(0, 5);
        $display("Test arbitration done");
        for (int r = 0; r < 8; r++) read_reg(0, r);
        nRes = 0;
        wfr[0] = 8'h08;
        emuxEn[0] = 1'b1;
        emuxCh[0] = 4'h3;
        ins(0, 4'h3);
        wait_valid(0, 3);
        seed = level[3];
        level[3] = ~level[3];
        ins(0, 4'h3);
        repeat (60) @(negedge sys_clk);
        cmp(busy[0], 1'b0, "stalled");
        read_reg(0, 3);
        cmp(d, exp_res(seed[9:0], 1'b0), "kept result");
        wait_valid(0, 3);
        read_reg(0, 3);
        cmp(d, exp_res(level[3], 1'b0), "later result");
        cmp(emuxSel[0], 3'h2, "ext mux step");
        cmp(nRes, 2, "result events");
        nLim = 0;
        limLo[0] = level[5] + 10'h001;
        check_conv(0, 4'h5);
        cmp(nLim, 1, "limit event");
        accN[0] = 3'h1;
        fifoEn[0] = 1'b1;
        repeat (2) begin
            ins(0, 4'h9);
            repeat (30) @(negedge sys_clk);
        end
        read_reg(0, 0);
        cmp(d, level[9] * 2, "accumulate in fifo");
        $display("Test results done");
        syncMode = 1'b1;
        ins(0, 4'h1);
        wait_valid(1, 5);
        read_reg(1, 5);
        cmp(d, exp_res(level[12], 1'b0), "slave result");
        syncMode = 1'b0;
        seed = xs(seed);
        portIn = seed[15:0];
        digDisable = seed[31:16];
        repeat (2) @(negedge sys_clk);
        cmp(digitalIn, portIn & ~digDisable, "digital input");
        $display("Test sync and port done");
        print_verdict();
    end
endmodule // tb_top
